// File: logic/fmcr_mode_regs.sv
// fmcr_mode_regs.sv: configuration and mode registers of the fsk modem
// assumes host on a plain strobe port and the same crystal clock;
// analog and task engines sit outside and take the decoded controls
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "fmcr_cfg.svh"

// Summary of operation
// - 8-bit write-only config: divider, sync tolerance, level mode, loop bandwidth.
// - config bits 7:6 select divide ratio 512, 1024, 2048 or 4096.
// - receive only, bits 5:4 allow 0, 2, 4 or 6 sync mismatches.
// - each adjacent level step counts one mismatch.
// - receive only, bits 3:2 pick hold, track, lossy or slow peak.
// - level acquisition forces slow peak detect until frame sync found.
// - hold level mode isolates offset capacitors from charge and discharge.
// - bits 1:0 pick loop bandwidth; clock acquisition overrides; transmit ignores.
// - hold bandwidth disables feedback; loop runs free at divided crystal.
// - second 8-bit write-only register holds operating modes.
// - bit 7 set drives interrupt pin low while interrupt status set.
// - bit 6 inverts symbol sense at transmit output and receive input.
// - bit 5 selects transmit; any change cancels the current task.
// - bit 4 in receive routes equalised signal to transmit buffer.
// - bit 3 powers down filters, extraction and transmit buffer.
// - after leaving powersave, treat filters unsettled about 20 symbols.
// - direction or powersave change sets buffer free without interrupt.
module fmcr_mode_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // host register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // task engine inputs
    input wire logic irqStatus,
    input wire logic levelAcquireSequence,
    input wire logic symbolClockAcquireSequence,
    input wire logic frameSyncFound,
    input wire logic [1:0] syncExpected,
    input wire logic [1:0] syncReceived,
    // sync search result
    output logic syncMismatchOk,
    // decoded receive controls
    output logic [1:0] levelMeasureMode,
    output logic offsetCapIsolate,
    output logic [1:0] clockLoopBandwidth,
    output logic loopFeedbackOn,
    output logic symbolTick,
    // decoded mode controls
    output logic interruptPinLowN,
    output logic symbolPolarityInvert,
    output logic directionSelect,
    output logic receiveEyeTest,
    output logic powersave,
    output logic filtersUnsettled,
    output logic taskCancel,
    output logic bufferFreeSet
);
    logic [7:0] rxCfg_r;
    logic [7:0] mode_r;
    logic [7:0] rdata_r;
    logic syncSeen_r;
    logic unsettled_r;
    logic cancel_r;
    logic buffer_free_flag_r;
    logic interrupt_pin_low_r;
    logic syncOk_r;
    logic [2:0] missTotal_r;
    logic [2:0] missTotal_nxt;
    logic [`FMCR_SETTLE_W-1:0] settle_r;
    logic [`FMCR_SETTLE_W-1:0] settle_nxt;
    fmcr_pkg::fmcr_pwr_t pwr_r;
    fmcr_pkg::fmcr_pwr_t pwr_nxt;
    logic [1:0] lev_r;
    logic capIso_r;
    logic [1:0] bw_r;
    logic fb_r;
    logic eye_r;
    logic tick;
    logic [1:0] steps;

    // address decode
    wire wrCfg = clkEn && regWr && (regAddr == `FMCR_ADDR_RXCFG);
    wire wrMode = clkEn && regWr && (regAddr == `FMCR_ADDR_MODE);

    // field views
    wire txMode = mode_r[`FMCR_DIR_BIT];
    wire [1:0] cfgDiv = rxCfg_r[`FMCR_DIV_HI:`FMCR_DIV_LO];
    wire [1:0] cfgTol = rxCfg_r[`FMCR_TOL_HI:`FMCR_TOL_LO];
    wire [1:0] cfgLev = rxCfg_r[`FMCR_LEV_HI:`FMCR_LEV_LO];
    wire [1:0] cfgBw = rxCfg_r[`FMCR_BW_HI:`FMCR_BW_LO];
    wire psaveBit = mode_r[`FMCR_POWERSAVE_BIT];

    // mode change detect against the new write
    wire dirChange = wrMode && (regWdata[`FMCR_DIR_BIT] != mode_r[`FMCR_DIR_BIT]);
    wire psChange = wrMode && (regWdata[`FMCR_POWERSAVE_BIT] != mode_r[`FMCR_POWERSAVE_BIT]);

    // effective level mode: acquisition forces slow peak until sync
    wire levForced = levelAcquireSequence && !frameSyncFound && !syncSeen_r;
    wire [1:0] levEff = levForced ? fmcr_pkg::FMCR_LEV_SLOWPK : cfgLev;

    // effective bandwidth: clock acquisition starts wide
    wire [1:0] bwEff = symbolClockAcquireSequence ? fmcr_pkg::FMCR_BW_WIDE : cfgBw;

    // tolerance 0/2/4/6 as twice the code
    // total saturates at 7, above the largest limit, so no wrap can pass a bad search
    wire [2:0] tolLimit = {cfgTol, 1'b0};
    wire [3:0] missSum = {1'b0, missTotal_r} + {2'b00, steps};
    assign missTotal_nxt = (missSum > 4'h7) ? 3'h7 : missSum[2:0];

    // divider stops while powered down
    fmcr_symbol_tick u_tick (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .divSel(cfgDiv),
        .run(!psaveBit),
        .tick(tick)
    );

    fmcr_sync_tol u_tol (
        .expected(syncExpected),
        .received(syncReceived),
        .steps(steps)
    );

    // host writes capture whole bytes; used from the next cycle on
    always_ff @(posedge clk) begin
        if (reset) begin
            rxCfg_r <= `FMCR_RXCFG_RST;
            mode_r <= `FMCR_MODE_RST;
        end else begin
            if (wrCfg) begin
                rxCfg_r <= regWdata;
            end
            if (wrMode) begin
                mode_r <= regWdata;
            end
        end
    end

    // write-only bank: reads give zero, no side effects
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (clkEn) begin
            rdata_r <= 8'h00;
        end
    end

    // direction change cancels the running task, one-cycle pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            cancel_r <= 1'b0;
        end else if (clkEn) begin
            cancel_r <= dirChange;
        end
    end

    // buffer free pulse; no interrupt request is raised from here
    always_ff @(posedge clk) begin
        if (reset) begin
            buffer_free_flag_r <= 1'b0;
        end else if (clkEn) begin
            buffer_free_flag_r <= dirChange || psChange;
        end
    end

    // mismatch accumulation; resets when frame sync is found or in transmit
    always_ff @(posedge clk) begin
        if (reset) begin
            missTotal_r <= 3'h0;
            syncOk_r <= 1'b0;
        end else if (clkEn) begin
            if (txMode || frameSyncFound) begin
                missTotal_r <= 3'h0;
                syncOk_r <= 1'b0;
            end else if (tick) begin
                missTotal_r <= missTotal_nxt;
                syncOk_r <= (missTotal_nxt <= tolLimit);
            end
        end
    end

    // powersave settle tracker, counted in symbol ticks
    always_comb begin
        pwr_nxt = pwr_r;
        settle_nxt = settle_r;
        case (pwr_r)
            fmcr_pkg::FMCR_PWR_RUN: begin
                if (psaveBit) begin
                    pwr_nxt = fmcr_pkg::FMCR_PWR_SAVE;
                end
            end
            fmcr_pkg::FMCR_PWR_SAVE: begin
                if (!psaveBit) begin
                    pwr_nxt = fmcr_pkg::FMCR_PWR_SETTLE;
                    settle_nxt = `FMCR_SETTLE_W'(`FMCR_SETTLE_SYMBOLS);
                end
            end
            fmcr_pkg::FMCR_PWR_SETTLE: begin
                if (psaveBit) begin
                    pwr_nxt = fmcr_pkg::FMCR_PWR_SAVE;
                end else if (settle_r == '0) begin
                    pwr_nxt = fmcr_pkg::FMCR_PWR_RUN;
                end else if (tick) begin
                    settle_nxt = settle_r - `FMCR_SETTLE_W'(1);
                end
            end
            default: begin
                pwr_nxt = fmcr_pkg::FMCR_PWR_RUN;
            end
        endcase
    end

    // power state and settle count
    always_ff @(posedge clk) begin
        if (reset) begin
            pwr_r <= fmcr_pkg::FMCR_PWR_RUN;
            settle_r <= '0;
        end else if (clkEn) begin
            pwr_r <= pwr_nxt;
            settle_r <= settle_nxt;
        end
    end

    // unsettled flag kept in its own flop so the pin never sees a state decode
    always_ff @(posedge clk) begin
        if (reset) begin
            unsettled_r <= 1'b0;
        end else if (clkEn) begin
            unsettled_r <= (pwr_nxt != fmcr_pkg::FMCR_PWR_RUN);
        end
    end

    // sync seen in this acquisition; a found pulse ends the forced peak mode until levelAcquireSequence drops
    always_ff @(posedge clk) begin
        if (reset) begin
            syncSeen_r <= 1'b0;
        end else if (clkEn) begin
            syncSeen_r <= levelAcquireSequence && (syncSeen_r || frameSyncFound);
        end
    end

    // registered level controls; transmit leaves them at hold
    always_ff @(posedge clk) begin
        if (reset) begin
            lev_r <= 2'h0;
            capIso_r <= 1'b1;
        end else if (clkEn) begin
            lev_r <= txMode ? 2'h0 : levEff;
            capIso_r <= txMode || (levEff == fmcr_pkg::FMCR_LEV_HOLD);
        end
    end

    // registered loop controls; transmit opens the loop
    always_ff @(posedge clk) begin
        if (reset) begin
            bw_r <= 2'h0;
            fb_r <= 1'b0;
        end else if (clkEn) begin
            bw_r <= txMode ? 2'h0 : bwEff;
            fb_r <= !txMode && (bwEff != fmcr_pkg::FMCR_BW_HOLD);
        end
    end

    // interrupt pin, one cycle behind the status bit
    always_ff @(posedge clk) begin
        if (reset) begin
            interrupt_pin_low_r <= 1'b1;
        end else if (clkEn) begin
            interrupt_pin_low_r <= !(mode_r[`FMCR_IRQEN_BIT] && irqStatus);
        end
    end

    // eye test only makes sense while receiving and powered
    always_ff @(posedge clk) begin
        if (reset) begin
            eye_r <= 1'b0;
        end else if (clkEn) begin
            eye_r <= mode_r[`FMCR_EYE_BIT] && !txMode && !psaveBit;
        end
    end

    // output assignment; invert, direction and powersave flags come straight from the register
    assign regRdata = rdata_r;
    assign syncMismatchOk = syncOk_r;
    assign levelMeasureMode = lev_r;
    assign offsetCapIsolate = capIso_r;
    assign clockLoopBandwidth = bw_r;
    assign loopFeedbackOn = fb_r;
    assign symbolTick = tick;
    assign interruptPinLowN = interrupt_pin_low_r;
    assign symbolPolarityInvert = mode_r[`FMCR_INV_BIT];
    assign directionSelect = mode_r[`FMCR_DIR_BIT];
    assign receiveEyeTest = eye_r;
    assign powersave = psaveBit;
    assign filtersUnsettled = unsettled_r;
    assign taskCancel = cancel_r;
    assign bufferFreeSet = buffer_free_flag_r;
endmodule : fmcr_mode_regs

// File: logic/fmcr_cfg.svh
// fmcr_cfg.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from package and design files
`ifndef FMCR_CFG_SVH
`define FMCR_CFG_SVH

// register addresses on the plain host port (3-bit address)
`define FMCR_ADDR_RXCFG 3'h0
`define FMCR_ADDR_MODE 3'h1
`define FMCR_ADDR_STAT 3'h2
`define FMCR_ADDR_EVT 3'h3

// field positions of symbol_rate_and_receive_config
`define FMCR_DIV_HI 7
`define FMCR_DIV_LO 6
`define FMCR_TOL_HI 5
`define FMCR_TOL_LO 4
`define FMCR_LEV_HI 3
`define FMCR_LEV_LO 2
`define FMCR_BW_HI 1
`define FMCR_BW_LO 0

// field positions of operating_mode_config
`define FMCR_IRQEN_BIT 7
`define FMCR_INV_BIT 6
`define FMCR_DIR_BIT 5
`define FMCR_EYE_BIT 4
`define FMCR_POWERSAVE_BIT 3

// reset values
`define FMCR_RXCFG_RST 8'h00
`define FMCR_MODE_RST 8'h00

// unsettled time after leaving powersave, in symbol times
`define FMCR_SETTLE_SYMBOLS 20
`define FMCR_SETTLE_W 5

// divider counter width covers the 4096 ratio
`define FMCR_DIVCNT_W 12

`endif

// File: logic/fmcr_pkg.sv
// fmcr_pkg.sv: types for the modem configuration register bank
// assumes fmcr_cfg.svh is on the include path
package fmcr_pkg;

    // level measurement modes
    typedef enum logic [1:0] {
        FMCR_LEV_HOLD = 2'h0,
        FMCR_LEV_TRACK = 2'h1,
        FMCR_LEV_LOSSY = 2'h2,
        FMCR_LEV_SLOWPK = 2'h3
    } fmcr_lev_t;

    // clock recovery loop bandwidths
    typedef enum logic [1:0] {
        FMCR_BW_HOLD = 2'h0,
        FMCR_BW_NARROW = 2'h1,
        FMCR_BW_MEDIUM = 2'h2,
        FMCR_BW_WIDE = 2'h3
    } fmcr_bw_t;

    // power state; on -> off -> settling -> on, one-bit steps except settling -> on
    typedef enum logic [1:0] {
        FMCR_PWR_RUN = 2'h0,
        FMCR_PWR_SAVE = 2'h1,
        FMCR_PWR_SETTLE = 2'h3
    } fmcr_pwr_t;

endpackage : fmcr_pkg

// File: logic/fmcr_symbol_tick.sv
// fmcr_symbol_tick.sv: crystal to symbol rate divider, one-cycle tick
// assumes clk is the crystal clock; ratio selected by a 2-bit code
`timescale 1ns/1ps
`include "fmcr_cfg.svh"
module fmcr_symbol_tick (
    // clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // divider setting
    input wire logic [1:0] divSel,
    input wire logic run,
    // symbol tick
    output logic tick
);
    logic [`FMCR_DIVCNT_W-1:0] cnt_r;
    logic [`FMCR_DIVCNT_W-1:0] cnt_nxt;
    logic [`FMCR_DIVCNT_W-1:0] lastCnt;
    logic tick_r;

    // 512 << code, minus one: terminal count
    assign lastCnt = {{(`FMCR_DIVCNT_W-9){1'b0}}, 9'h1FF} << divSel |
                     ((`FMCR_DIVCNT_W'(1) << divSel) - `FMCR_DIVCNT_W'(1));
    assign cnt_nxt = (!run || cnt_r >= lastCnt) ? '0 : cnt_r + `FMCR_DIVCNT_W'(1);
    assign tick = tick_r;

    // counter restarts when divider stopped, so a new ratio takes clean effect
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (clkEn) begin
            cnt_r <= cnt_nxt;
            tick_r <= run && (cnt_r >= lastCnt);
        end
    end
endmodule : fmcr_symbol_tick

// File: logic/fmcr_sync_tol.sv
// fmcr_sync_tol.sv: frame sync mismatch weight for one symbol
// assumes symbols coded 00=-3 01=-1 10=+1 11=+3 (level order)
`timescale 1ns/1ps
module fmcr_sync_tol (
    // symbols
    input wire logic [1:0] expected,
    input wire logic [1:0] received,
    // mismatch steps, 0 to 3
    output logic [1:0] steps
);
    // one step per adjacent level distance
    assign steps = (expected > received) ? expected - received
                                         : received - expected;
endmodule : fmcr_sync_tol

// File: dv/fmcr_mode_regs_assertions.sv
// fmcr_mode_regs_assertions.sv: port checks of the mode register bank
// assumes bind onto fmcr_mode_regs, one clock, sync active-high reset
`timescale 1ns/1ps
module fmcr_mode_regs_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // host port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // controls
    input wire logic irqStatus,
    input wire logic syncMismatchOk,
    input wire logic offsetCapIsolate,
    input wire logic loopFeedbackOn,
    input wire logic symbolTick,
    input wire logic interruptPinLowN,
    input wire logic symbolPolarityInvert,
    input wire logic directionSelect,
    input wire logic powersave,
    input wire logic filtersUnsettled,
    input wire logic taskCancel,
    input wire logic bufferFreeSet
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // accepted mode writes and the bits they flip
    wire modeWr = regWr && clkEn && regAddr == 3'h1;
    wire dirFlip = modeWr && regWdata[5] != directionSelect;
    wire pwrFlip = modeWr && regWdata[3] != powersave;
    // cancel is a single pulse, not a level
    sequence cancelPulse;
        taskCancel ##1 !taskCancel;
    endsequence
    a_mode_capture: assert property (modeWr |=> directionSelect == $past(regWdata[5])
        && symbolPolarityInvert == $past(regWdata[6])) else $error("mode byte not applied");
    a_cancel_pulse: assert property (dirFlip ##1 !dirFlip |-> cancelPulse)
        else $error("no cancel pulse");
    a_cancel_only_flip: assert property (modeWr && !dirFlip |=> !taskCancel)
        else $error("spurious cancel");
    a_buffer_free: assert property (dirFlip || pwrFlip |=> bufferFreeSet)
        else $error("buffer free not set");
    a_read_empty: assert property (regRd |=> regRdata == 8'h00)
        else $error("read returned data");
    a_irq_pin_high: assert property (clkEn && !irqStatus |=> interruptPinLowN)
        else $error("irq pin low without status");
    a_powersave_no_tick: assert property (powersave && $past(powersave) |-> !symbolTick)
        else $error("tick in powersave");
    a_powersave_unsettled: assert property (powersave && $past(powersave) |-> filtersUnsettled)
        else $error("filters settled in powersave");
    a_tx_ignores_rx: assert property (directionSelect && $past(directionSelect)
        |-> offsetCapIsolate && !loopFeedbackOn && !syncMismatchOk) else $error("rx fields in tx");
endmodule : fmcr_mode_regs_assertions

// File: dv/fmcr_host_model.sv
// fmcr_host_model.sv: host processor driving the register port
// assumes the shared crystal clock; signals change just after rising edges
`timescale 1ns/1ps
module fmcr_host_model (
    // clock
    input wire logic clk,
    // host port
    output logic [2:0] regAddr,
    output logic [7:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [7:0] regRdata
);
    // idle bus from time zero
    initial begin
        regAddr = 3'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // one-cycle write; data inverted after so stale bytes never look valid
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= (a == 3'h1) ? (d & 8'hF8) : d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regWdata <= ~d;
    endtask : wr
    // one-cycle read; data taken at the following edge only
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        d = regRdata;
    endtask : rd
endmodule : fmcr_host_model

// File: dv/testbench.sv
// testbench.sv: directed checks of the modem mode register bank
// assumes checker and host model compiled first; clkEn high except in the freeze check
`timescale 1ns/1ps
module testbench;
    logic clk, reset, clkEn, regWr, regRd, irqStatus, frameSyncFound;
    logic levelAcquireSequence, symbolClockAcquireSequence, syncMismatchOk, offsetCapIsolate;
    logic loopFeedbackOn, symbolTick, interruptPinLowN, symbolPolarityInvert, directionSelect;
    logic receiveEyeTest, powersave, filtersUnsettled, taskCancel, bufferFreeSet;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [1:0] syncExpected, syncReceived, levelMeasureMode, clockLoopBandwidth;
    int errors, tests_run;
    fmcr_mode_regs dut_u (.clk, .reset, .clkEn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .irqStatus, .levelAcquireSequence, .symbolClockAcquireSequence, .frameSyncFound,
        .syncExpected, .syncReceived, .syncMismatchOk, .levelMeasureMode, .offsetCapIsolate,
        .clockLoopBandwidth, .loopFeedbackOn, .symbolTick, .interruptPinLowN,
        .symbolPolarityInvert, .directionSelect, .receiveEyeTest, .powersave,
        .filtersUnsettled, .taskCancel, .bufferFreeSet);
    fmcr_host_model host_u (.clk, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
    // 10 MHz crystal clock; short ratios used for speed, long ones give in-range rates
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // derived outputs lag the write by two edges
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    // bounded wait for the next symbol tick, returns cycles waited
    task wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (symbolTick !== 1'b1 && n < 5000);
        if (n >= 5000) chk("tickWait", 16'h0000, 16'h0001);
    endtask : wait_tick
    // clear the total just after a tick, so no tick is missed, then receive rcv against +1
    task sync_run(input logic [1:0] rcv, input int ticks, input logic ok);
        int n;
        wait_tick(n);
        @(posedge clk) frameSyncFound <= 1'b1;
        @(posedge clk) frameSyncFound <= 1'b0;
        syncReceived <= rcv;
        repeat (ticks) wait_tick(n);
        settle;
        chk("syncOk", {15'h0000, ok}, {15'h0000, syncMismatchOk});
    endtask : sync_run
    task print_verdict;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // hang guard, about twice the expected run
    initial begin
        #6000000;
        errors++;
        print_verdict;
    end
    // main sequence
    initial begin
        int n;
        logic [7:0] d;
        errors = 0;
        tests_run = 0;
        {reset, clkEn} = 2'h3;
        {irqStatus, levelAcquireSequence, symbolClockAcquireSequence, frameSyncFound} = 4'h0;
        syncExpected = 2'h2;
        syncReceived = 2'h2;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("resetOuts", 16'h00C0, {regRdata, interruptPinLowN, offsetCapIsolate, directionSelect,
            powersave, loopFeedbackOn, taskCancel, bufferFreeSet, filtersUnsettled});
        host_u.wr(3'h5, 8'hFF);
        host_u.rd(3'h1, d);
        chk("readData", 16'h0000, {8'h00, d});
        chk("unmapped", 16'h0000, {directionSelect, powersave, symbolPolarityInvert});
        for (int i = 0; i < 4; i++) begin
            host_u.wr(3'h0, {4'h1, i[1:0], i[1:0]});
            settle;
            chk("rxCtl", {i[1:0], i[1:0], i == 0, i != 0}, {levelMeasureMode,
                clockLoopBandwidth, offsetCapIsolate, loopFeedbackOn});
        end
        host_u.wr(3'h0, 8'h26);
        @(posedge clk) levelAcquireSequence <= 1'b1;
        settle;
        chk("acqLevel", 16'h0003, levelMeasureMode);
        @(posedge clk) frameSyncFound <= 1'b1;
        @(posedge clk) frameSyncFound <= 1'b0;
        settle;
        chk("foundLevel", 16'h0001, levelMeasureMode);
        @(posedge clk) {levelAcquireSequence, symbolClockAcquireSequence} <= 2'h1;
        settle;
        chk("acqLoop", 16'h0003, clockLoopBandwidth);
        @(posedge clk) symbolClockAcquireSequence <= 1'b0;
        settle;
        chk("normLoop", 16'h0002, clockLoopBandwidth);
        sync_run(2'h3, 4, 1'b1);
        sync_run(2'h3, 5, 1'b0);
        sync_run(2'h0, 2, 1'b1);
        sync_run(2'h0, 3, 1'b0);
        for (int i = 0; i < 4; i++) begin
            host_u.wr(3'h0, {i[1:0], 6'h16});
            wait_tick(n);
            wait_tick(n);
            chk("tickPeriod", 16'h0200 << i, n[15:0]);
        end
        host_u.wr(3'h0, 8'h16);
        host_u.wr(3'h1, 8'h20);
        #1 chk("txPulses", 16'h0003, {taskCancel, bufferFreeSet});
        settle;
        chk("txIgnore", 16'h0004, {levelMeasureMode, clockLoopBandwidth,
            offsetCapIsolate, loopFeedbackOn, syncMismatchOk});
        host_u.wr(3'h1, 8'h08);
        #1 chk("psavePulses", 16'h0003, {taskCancel, bufferFreeSet});
        n = 0;
        repeat (600) begin
            @(posedge clk);
            #1;
            if (symbolTick === 1'b1) n++;
        end
        chk("psaveTicks", 16'h0001, {n[14:0], filtersUnsettled});
        host_u.wr(3'h1, 8'h00);
        #1 chk("wakePulses", 16'h0001, {taskCancel, bufferFreeSet});
        repeat (19) wait_tick(n);
        chk("stillUnsettled", 16'h0001, filtersUnsettled);
        repeat (1) wait_tick(n);
        settle;
        chk("settled", 16'h0000, filtersUnsettled);
        host_u.wr(3'h1, 8'hD0);
        settle;
        chk("modeBits", 16'h0003, {symbolPolarityInvert, receiveEyeTest});
        @(posedge clk) irqStatus <= 1'b1;
        settle;
        chk("irqLow", 16'h0000, interruptPinLowN);
        host_u.wr(3'h1, 8'h30);
        settle;
        chk("eyeTxIrqOff", 16'h0001, {receiveEyeTest, interruptPinLowN});
        @(posedge clk) clkEn <= 1'b0;
        host_u.wr(3'h1, 8'h08);
        #1 chk("frozen", 16'h0008, {directionSelect, powersave, taskCancel, bufferFreeSet});
        @(posedge clk) clkEn <= 1'b1;
        @(posedge clk) reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("midReset", 16'h00C0, {regRdata, interruptPinLowN, offsetCapIsolate,
            directionSelect, powersave, loopFeedbackOn, taskCancel, bufferFreeSet,
            filtersUnsettled});
        print_verdict;
    end
endmodule : testbench
bind fmcr_mode_regs fmcr_mode_regs_assertions chk_u (.clk, .reset, .clkEn, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .irqStatus, .syncMismatchOk, .offsetCapIsolate, .loopFeedbackOn,
    .symbolTick, .interruptPinLowN, .symbolPolarityInvert, .directionSelect, .powersave,
    .filtersUnsettled, .taskCancel, .bufferFreeSet);
